// ---- rrsb_alu.sv ----
/*
 * Eight-bit rotate-right and subtract-with-borrow datapath slice.
 * Holds the working register and the status flags it touches.
 * Assumes the core presents one operation per clock with its memory
 * operand, and writes memory from the write strobe one cycle later.
 */
// Functional notes
// - Memory rotate-right moves bit 0 to bit 7, writes memory back, touches no flag.
// - Rotate-right to the working register gives the same rotation, memory and flags unchanged.
// - Memory rotate through carry loads old carry into bit 7 and old bit 0 into carry.
// - Rotate through carry to the working register does the same loop, memory unchanged.
// - Subtract to the working register stores work minus memory minus inverted carry there.
// - Subtract to memory writes that difference to memory, working register unchanged.
// - After a subtract carry is 0 when the true difference is negative, else 1.
// - Subtracts update six flags; rotates through carry update only carry.
module rrsb_alu
  import rrsb_pkg::*;
#(
  parameter int unsigned DATA_W = RRSB_DATA_W
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic op_valid_i,
  input wire rrsb_op_t op_i,
  input wire logic [DATA_W-1:0] mem_operand_i,
  input wire logic work_load_i,
  input wire logic [DATA_W-1:0] work_load_data_i,
  input wire logic carry_load_i,
  input wire logic carry_load_data_i,
  output logic [DATA_W-1:0] working_register_o,
  output logic carry_flag_o,
  output logic twos_complement_wrap_flag_o,
  output logic zero_flag_o,
  output logic nibble_carry_flag_o,
  output logic second_compare_flag_o,
  output logic combined_null_flag_o,
  output logic mem_wr_en_o,
  output logic [DATA_W-1:0] mem_wr_data_o,
  output logic done_o
);
  typedef struct packed {
    logic [DATA_W-1:0] work;
    logic carry;
    logic ovf;
    logic zero;
    logic nibble;
    logic scmp;
    logic cnull;
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
    logic done;
  } rrsb_state_t;

  rrsb_state_t st;
  rrsb_state_t next_st;
  rrsb_op_t act_op;
  logic [DATA_W-1:0] calc_result;
  logic calc_carry;
  logic calc_ovf;
  logic calc_zero;
  logic calc_nibble;
  logic calc_neg;

  // Idle op keeps the calculator output meaningless but harmless
  assign act_op = op_valid_i ? op_i : RRSB_OP_IDLE;

  rrsb_calc #(
    .DATA_W(DATA_W)
  ) u_calc (
    .op_i(act_op),
    .work_i(st.work),
    .mem_i(mem_operand_i),
    .carry_i(st.carry),
    .result_o(calc_result),
    .carry_o(calc_carry),
    .ovf_o(calc_ovf),
    .zero_o(calc_zero),
    .nibble_o(calc_nibble),
    .neg_o(calc_neg)
  );

  // Next state; a valid operation wins over a direct load of a field it writes, and a memory subtract also blocks the work load
  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    next_st.done = 1'b0;
    if (work_load_i) begin
      next_st.work = work_load_data_i;
    end
    if (carry_load_i) begin
      next_st.carry = carry_load_data_i;
    end
    if (op_valid_i && act_op != RRSB_OP_IDLE) begin
      next_st.done = 1'b1;
      case (act_op)
        RRSB_OP_ROT_MEM: begin
          next_st.wr_en = 1'b1; // Flags held
          next_st.wr_data = calc_result;
        end
        RRSB_OP_ROT_WORK: begin
          next_st.work = calc_result;
        end
        RRSB_OP_ROTC_MEM: begin
          next_st.wr_en = 1'b1;
          next_st.wr_data = calc_result;
          next_st.carry = calc_carry; // Only carry moves
        end
        RRSB_OP_ROTC_WORK: begin
          next_st.work = calc_result;
          next_st.carry = calc_carry;
        end
        RRSB_OP_SUBB_WORK, RRSB_OP_SUBB_MEM: begin
          if (act_op == RRSB_OP_SUBB_WORK) begin
            next_st.work = calc_result;
          end else begin
            next_st.work = st.work; // Ignore a same-cycle load
            next_st.wr_en = 1'b1;
            next_st.wr_data = calc_result;
          end
          next_st.carry = calc_carry;
          next_st.ovf = calc_ovf;
          next_st.zero = calc_zero;
          next_st.nibble = calc_nibble;
          // Signed less-than after the subtract
          next_st.scmp = calc_neg ^ calc_ovf;
          // Zero chained across multi-byte subtracts
          next_st.cnull = calc_zero & st.zero;
        end
        default: begin
          next_st.done = 1'b0;
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '{work: DATA_W'(RRSB_WORK_RST), carry: RRSB_FLAG_RST, ovf: RRSB_FLAG_RST,
              zero: RRSB_FLAG_RST, nibble: RRSB_FLAG_RST, scmp: RRSB_FLAG_RST,
              cnull: RRSB_FLAG_RST, wr_en: 1'b0, wr_data: DATA_W'(RRSB_WORK_RST),
              done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign working_register_o = st.work;
  assign carry_flag_o = st.carry;
  assign twos_complement_wrap_flag_o = st.ovf;
  assign zero_flag_o = st.zero;
  assign nibble_carry_flag_o = st.nibble;
  assign second_compare_flag_o = st.scmp;
  assign combined_null_flag_o = st.cnull;
  assign mem_wr_en_o = st.wr_en;
  assign mem_wr_data_o = st.wr_data;
  assign done_o = st.done;

  // Checks
  sequence s_op(rrsb_op_t o);
    op_valid_i && op_i == o;
  endsequence

  chk_rot_mem_wrap: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_ROT_MEM) |=> mem_wr_en_o &&
      mem_wr_data_o == {$past(mem_operand_i[0]), $past(mem_operand_i[DATA_W-1:1])} &&
      carry_flag_o == ($past(carry_load_i) ? $past(carry_load_data_i) : $past(carry_flag_o)) &&
      $stable(zero_flag_o))
    else $error("memory rotate result or flags wrong");

  chk_rot_work_only: assert property (@(posedge core_clk_i) disable iff (srst_i)
    // A carry load beside this op still acts, so carry follows the load only
    s_op(RRSB_OP_ROT_WORK) |=> !mem_wr_en_o &&
      carry_flag_o == ($past(carry_load_i) ? $past(carry_load_data_i) : $past(carry_flag_o)) &&
      working_register_o == {$past(mem_operand_i[0]), $past(mem_operand_i[DATA_W-1:1])})
    else $error("rotate to working register wrong");

  chk_rotc_mem_loop: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_ROTC_MEM) |=> mem_wr_en_o && carry_flag_o == $past(mem_operand_i[0]) &&
      mem_wr_data_o[DATA_W-1] == $past(carry_flag_o))
    else $error("memory rotate through carry wrong");

  chk_rotc_work_loop: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_ROTC_WORK) |=> !mem_wr_en_o && carry_flag_o == $past(mem_operand_i[0]) &&
      working_register_o == {$past(carry_flag_o), $past(mem_operand_i[DATA_W-1:1])})
    else $error("rotate through carry to working register wrong");

  chk_subb_work_val: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_SUBB_WORK) |=> !mem_wr_en_o && working_register_o ==
      DATA_W'($past(working_register_o) - $past(mem_operand_i) - DATA_W'(!$past(carry_flag_o))))
    else $error("subtract to working register wrong");

  chk_subb_mem_val: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_SUBB_MEM) |=> mem_wr_en_o && $stable(working_register_o) && mem_wr_data_o ==
      DATA_W'($past(working_register_o) - $past(mem_operand_i) - DATA_W'(!$past(carry_flag_o))))
    else $error("subtract to memory wrong");

  chk_subb_carry_sign: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_op(RRSB_OP_SUBB_WORK) or s_op(RRSB_OP_SUBB_MEM)) |=> carry_flag_o ==
      ({1'b0, $past(working_register_o)} >= {1'b0, $past(mem_operand_i)} +
       (DATA_W+1)'(!$past(carry_flag_o))))
    else $error("borrow flag wrong after subtract");

  chk_rotc_flags_kept: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (s_op(RRSB_OP_ROTC_MEM) or s_op(RRSB_OP_ROTC_WORK)) |=> $stable(zero_flag_o) &&
      $stable(twos_complement_wrap_flag_o) && $stable(nibble_carry_flag_o) &&
      $stable(second_compare_flag_o) && $stable(combined_null_flag_o))
    else $error("rotate through carry touched other flags");

  chk_subb_zero_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_SUBB_MEM) |=> zero_flag_o == (mem_wr_data_o == '0) &&
      nibble_carry_flag_o == ({1'b0, $past(working_register_o[RRSB_NIB_W-1:0])} >=
        {1'b0, $past(mem_operand_i[RRSB_NIB_W-1:0])} + (RRSB_NIB_W+1)'(!$past(carry_flag_o))))
    else $error("zero or nibble flag disagrees with difference");

  // Overflow only when operand signs differ and the result sign flips
  chk_subb_ovf_sign: assert property (@(posedge core_clk_i) disable iff (srst_i)
    s_op(RRSB_OP_SUBB_WORK) |=> twos_complement_wrap_flag_o ==
      (($past(working_register_o[DATA_W-1]) != $past(mem_operand_i[DATA_W-1])) &&
       (working_register_o[DATA_W-1] != $past(working_register_o[DATA_W-1]))))
    else $error("overflow flag wrong after subtract");

  // An idle cycle must not pulse done or the write strobe, or disturb the wrap and zero flags
  chk_idle_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!op_valid_i || op_i == RRSB_OP_IDLE) |=> !done_o && !mem_wr_en_o &&
      $stable(twos_complement_wrap_flag_o) && $stable(zero_flag_o))
    else $error("idle cycle changed outputs");
endmodule // rrsb_alu

// ---- rrsb_pkg.sv ----
/*
 * Shared constants and types of the rotate-right / subtract-with-borrow
 * datapath slice. Assumes it is compiled before every module that uses it.
 */
package rrsb_pkg;
  localparam int unsigned RRSB_DATA_W = 8;
  localparam int unsigned RRSB_MSB = RRSB_DATA_W - 1;
  localparam int unsigned RRSB_NIB_W = 4;
  localparam logic [7:0] RRSB_WORK_RST = 8'h00;
  localparam logic RRSB_FLAG_RST = 1'h0;

  // Operation select; OP_IDLE does nothing
  typedef enum logic [2:0] {
    RRSB_OP_IDLE,
    RRSB_OP_ROT_MEM,
    RRSB_OP_ROT_WORK,
    RRSB_OP_ROTC_MEM,
    RRSB_OP_ROTC_WORK,
    RRSB_OP_SUBB_WORK,
    RRSB_OP_SUBB_MEM
  } rrsb_op_t;
endpackage : rrsb_pkg

// ---- rrsb_calc.sv ----
/*
 * Combinational result and flag calculator for one operation.
 * Assumes the caller registers every output it presents at the pins.
 */
module rrsb_calc
  import rrsb_pkg::*;
#(
  parameter int unsigned DATA_W = RRSB_DATA_W
) (
  input wire rrsb_op_t op_i,
  input wire logic [DATA_W-1:0] work_i,
  input wire logic [DATA_W-1:0] mem_i,
  input wire logic carry_i,
  output logic [DATA_W-1:0] result_o,
  output logic carry_o,
  output logic ovf_o,
  output logic zero_o,
  output logic nibble_o,
  output logic neg_o
);
  logic [DATA_W:0] diff;
  logic [RRSB_NIB_W:0] low_diff;
  logic borrow_in;

  // Subtract with borrow: the stored carry is an inverted borrow
  always_comb begin
    borrow_in = ~carry_i;
    diff = {1'b0, work_i} - {1'b0, mem_i} - {{DATA_W{1'b0}}, borrow_in};
    low_diff = {1'b0, work_i[RRSB_NIB_W-1:0]} - {1'b0, mem_i[RRSB_NIB_W-1:0]}
      - {{RRSB_NIB_W{1'b0}}, borrow_in};
  end

  // Result and flags per operation
  always_comb begin
    result_o = work_i;
    carry_o = carry_i;
    ovf_o = 1'b0;
    zero_o = 1'b0;
    nibble_o = 1'b0;
    neg_o = 1'b0;
    case (op_i)
      RRSB_OP_ROT_MEM, RRSB_OP_ROT_WORK: begin
        result_o = {mem_i[0], mem_i[DATA_W-1:1]};
      end
      RRSB_OP_ROTC_MEM, RRSB_OP_ROTC_WORK: begin
        result_o = {carry_i, mem_i[DATA_W-1:1]};
        carry_o = mem_i[0];
      end
      RRSB_OP_SUBB_WORK, RRSB_OP_SUBB_MEM: begin
        result_o = diff[DATA_W-1:0];
        carry_o = ~diff[DATA_W]; // No borrow means zero or positive
        zero_o = (diff[DATA_W-1:0] == '0);
        nibble_o = ~low_diff[RRSB_NIB_W];
        ovf_o = (work_i[DATA_W-1] != mem_i[DATA_W-1]) &&
                (diff[DATA_W-1] != work_i[DATA_W-1]);
        neg_o = diff[DATA_W-1];
      end
      default: begin
        result_o = work_i;
      end
    endcase
  end
endmodule // rrsb_calc

// ---- rrsb_alu_tb.sv ----
/*
 Self-checking bench for rrsb_alu: reset, a table of single operations, then
 back-to-back, load clash, idle and mid-run reset cases.
 Assumes rrsb_pkg is compiled first and the assertions sit in the design.
*/
module rrsb_alu_tb
  import rrsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {rrsb_op_t op; logic [7:0] w; logic c; logic [7:0] m;} rrsb_row_t;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic vld = 1'h0;
  logic wl = 1'h0;
  logic cl = 1'h0;
  logic cld = 1'h0;
  logic [7:0] mem = 8'h00;
  logic [7:0] wld = 8'h00;
  rrsb_op_t op = RRSB_OP_IDLE;
  logic [7:0] work, wdat, e_work, e_wd;
  logic c, ov, z, ac, sc, cz, we, done;
  logic e_c, e_ov, e_z, e_ac, e_sc, e_cz, e_we, e_done;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // Boundary cases: wrap bits, borrow in, borrow out, overflow, zero chain
  rrsb_row_t rows [10] = '{
    '{RRSB_OP_ROT_MEM, 8'h00, 1'h0, 8'h81}, '{RRSB_OP_ROT_WORK, 8'h00, 1'h1, 8'h01},
    '{RRSB_OP_ROTC_MEM, 8'h00, 1'h1, 8'h02}, '{RRSB_OP_ROTC_WORK, 8'h00, 1'h0, 8'h03},
    '{RRSB_OP_SUBB_WORK, 8'h50, 1'h1, 8'h20}, '{RRSB_OP_SUBB_WORK, 8'h10, 1'h0, 8'h10},
    '{RRSB_OP_SUBB_WORK, 8'h80, 1'h1, 8'h01}, '{RRSB_OP_SUBB_MEM, 8'h20, 1'h0, 8'h1f},
    '{RRSB_OP_SUBB_MEM, 8'h01, 1'h1, 8'h01}, '{RRSB_OP_SUBB_MEM, 8'h7f, 1'h1, 8'hff}};

  rrsb_alu i_rrsb_alu (.core_clk_i(clk), .srst_i(srst), .op_valid_i(vld), .op_i(op),
    .mem_operand_i(mem), .work_load_i(wl), .work_load_data_i(wld), .carry_load_i(cl),
    .carry_load_data_i(cld), .working_register_o(work), .carry_flag_o(c),
    .twos_complement_wrap_flag_o(ov), .zero_flag_o(z), .nibble_carry_flag_o(ac),
    .second_compare_flag_o(sc), .combined_null_flag_o(cz), .mem_wr_en_o(we),
    .mem_wr_data_o(wdat), .done_o(done));

  initial forever #25 clk = ~clk;

  // Hang guard: the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic check_all();
    chk8(work, e_work, "work");
    chk8(wdat, e_wd, "wr data");
    chk1(we, e_we, "wr en");
    chk1(done, e_done, "done");
    chk1(c, e_c, "carry");
    chk1(ov, e_ov, "ovf");
    chk1(z, e_z, "zero");
    chk1(ac, e_ac, "nibble");
    chk1(sc, e_sc, "second");
    chk1(cz, e_cz, "chain zero");
  endtask

  // Present one op and advance the reference state; memory kept outside
  task automatic issue(input rrsb_op_t o, input logic [7:0] m);
    logic [8:0] d;
    logic [4:0] n;
    logic [7:0] r;
    op = o;
    mem = m;
    vld = 1'h1;
    e_done = 1'h1;
    e_we = 1'h0;
    r = {e_c, m[7:1]};
    d = {1'h0, e_work} - {1'h0, m} - {8'h00, ~e_c};
    n = {1'h0, e_work[3:0]} - {1'h0, m[3:0]} - {4'h0, ~e_c};
    case (o)
      RRSB_OP_ROT_MEM, RRSB_OP_ROT_WORK: r = {m[0], m[7:1]};
      RRSB_OP_ROTC_MEM, RRSB_OP_ROTC_WORK: e_c = m[0];
      default: begin
        r = d[7:0];
        e_c = ~d[8];
        e_ac = ~n[4];
        e_ov = (e_work[7] != m[7]) && (r[7] != e_work[7]);
        e_cz = (r == 8'h00) && e_z;
        e_z = (r == 8'h00);
        e_sc = r[7] ^ e_ov;
      end
    endcase
    if (o == RRSB_OP_ROT_MEM || o == RRSB_OP_ROTC_MEM || o == RRSB_OP_SUBB_MEM) begin
      e_we = 1'h1;
      e_wd = r;
    end else begin
      e_work = r;
    end
  endtask

  task automatic idle();
    vld = 1'h0;
    op = RRSB_OP_IDLE;
    wl = 1'h0;
    cl = 1'h0;
    e_done = 1'h0;
    e_we = 1'h0;
  endtask

  task automatic set_regs(input logic [7:0] w, input logic cv);
    @(negedge clk);
    wl = 1'h1;
    wld = w;
    cl = 1'h1;
    cld = cv;
    e_work = w;
    e_c = cv;
    @(negedge clk);
    idle();
  endtask

  task automatic do_reset();
    @(negedge clk);
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    {e_work, e_wd, e_c, e_ov, e_z, e_ac, e_sc, e_cz, e_we, e_done} = '0;
    check_all();
    $display("test reset done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      set_regs(rows[i].w, rows[i].c);
      @(negedge clk);
      issue(rows[i].op, rows[i].m);
      @(negedge clk);
      check_all();
      idle();
    end
    $display("test table done");
    // Back to back: borrow from the low byte feeds the high byte
    set_regs(8'h00, 1'h1);
    @(negedge clk);
    issue(RRSB_OP_SUBB_WORK, 8'h01);
    @(negedge clk);
    check_all();
    issue(RRSB_OP_SUBB_MEM, 8'h00);
    @(negedge clk);
    check_all();
    idle();
    $display("test chain done");
    // Loads lose against ops that write the same place, act beside a memory rotate
    @(negedge clk);
    issue(RRSB_OP_ROTC_WORK, 8'h01);
    wl = 1'h1;
    wld = 8'h5a;
    cl = 1'h1;
    cld = ~e_c;
    @(negedge clk);
    check_all();
    issue(RRSB_OP_ROT_MEM, 8'h02);
    wld = 8'h3c;
    cld = 1'h1;
    e_work = 8'h3c;
    e_c = 1'h1;
    @(negedge clk);
    check_all();
    idle();
    $display("test load clash done");
    // Op without valid must leave everything alone
    @(negedge clk);
    op = RRSB_OP_SUBB_MEM;
    mem = 8'h11;
    @(negedge clk);
    op = RRSB_OP_IDLE;
    check_all();
    $display("test idle done");
    do_reset();
    // First op right at the first edge after release
    issue(RRSB_OP_ROT_WORK, 8'h81);
    @(negedge clk);
    check_all();
    idle();
    $display("test op after reset done");
    report_and_stop();
  end
endmodule // rrsb_alu_tb
